//--- tb/tb_rgbl_top.sv
// Self-checking bench for the radiation guard and blanking logic.
// Assumes rgbl_top with its Avalon-MM slave and the offsets of rgbl_regs.svh.
`timescale 1ns/1ns
`default_nettype none
`include "rgbl_regs.svh"
module tb_rgbl_top;
    logic                    ref_clk;
    logic                    rst_b;
    logic [`RGBL_ADDR_W-1:0] avs_address;
    logic                    avs_read;
    logic                    avs_write;
    logic [31:0]             avs_writedata;
    logic [3:0]              avs_byteenable;
    logic [31:0]             avs_readdata;
    logic                    avs_waitrequest;
    logic                    radiation;
    logic                    line_pulse;
    logic                    vsync;
    logic                    vdischarge;
    logic                    loop_lock;
    logic                    supply_ok;
    logic                    line_drv;
    logic                    conv_drv;
    logic [1:0]              comp;
    logic                    irq;
    int                      failures;
    int                      n_checks;

    rgbl_top rgbl_top_i (
        .ref_clk_i                  (ref_clk),
        .rst_b_i                    (rst_b),
        .avs_address_i              (avs_address),
        .avs_read_i                 (avs_read),
        .avs_write_i                (avs_write),
        .avs_writedata_i            (avs_writedata),
        .avs_byteenable_i           (avs_byteenable),
        .avs_readdata_o             (avs_readdata),
        .avs_waitrequest_o          (avs_waitrequest),
        .radiation_sense_i          (radiation),
        .line_pulse_i               (line_pulse),
        .vsync_i                    (vsync),
        .vdischarge_i               (vdischarge),
        .loop_lock_i                (loop_lock),
        .supply_ok_i                (supply_ok),
        .line_drive_out_o           (line_drv),
        .converter_drive_out_o      (conv_drv),
        .lock_blank_composite_out_o (comp),
        .irq_o                      (irq)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // The request is held until waitrequest is sampled low at an edge.
    // One idle edge follows each access so no strobe is set twice at once.
    task bus(input logic [4:0] a, input logic is_wr, input logic [31:0] d,
             output logic [31:0] v);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= is_wr;
        avs_read      <= ~is_wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50)
            check(32'h1, 32'h0, "bus answer missing");
        v = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge ref_clk);
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(a, 1'b1, d, v);
    endtask

    task rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(a, 1'b0, `RGBL_ZERO32, v);
        check(v, exp, "register read");
    endtask

    // Inputs pass two sync flops plus one or two registers, so five edges settle.
    task comp_chk(input logic [1:0] exp);
        wait_n(5);
        check({30'h0, comp}, {30'h0, exp}, "composite level");
    endtask

    task tick;
        line_pulse <= 1'b1;
        wait_n(3);
        line_pulse <= 1'b0;
        wait_n(3);
    endtask

    initial
    begin
        wait_n(5000);
        failures++;
        print_verdict();
    end

    initial
    begin
        failures      = 0;
        n_checks      = 0;
        rst_b         = 1'b0;
        avs_address   = '0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = `RGBL_ZERO32;
        avs_byteenable = 4'hF;
        radiation     = 1'b0;
        line_pulse    = 1'b0;
        vsync         = 1'b0;
        vdischarge    = 1'b0;
        loop_lock     = 1'b1;
        supply_ok     = 1'b1;
        wait_n(5);
        rst_b <= 1'b1;
        wait_n(6);

        rd_chk(`RGBL_OFS_CTRL, 32'h0000_0006);
        rd_chk(`RGBL_OFS_RAMP, 32'h0000_0010);
        rd_chk(`RGBL_OFS_IRQ_MASK, `RGBL_ZERO32);
        rd_chk(`RGBL_OFS_IRQ_STAT, `RGBL_ZERO32);
        wr(5'h14, 32'hFFFF_FFFF);
        rd_chk(5'h14, `RGBL_ZERO32);
        avs_byteenable <= 4'hE;
        wr(`RGBL_OFS_CTRL, `RGBL_ZERO32);
        avs_byteenable <= 4'hF;
        rd_chk(`RGBL_OFS_CTRL, 32'h0000_0006);
        $display("test reset values done");

        comp_chk(2'h3);
        loop_lock <= 1'b0;
        comp_chk(2'h2);
        rd_chk(`RGBL_OFS_IRQ_STAT, 32'h0000_0002);
        wr(`RGBL_OFS_IRQ_STAT, 32'h0000_0002);
        rd_chk(`RGBL_OFS_IRQ_STAT, `RGBL_ZERO32);
        loop_lock <= 1'b1;
        wr(`RGBL_OFS_CTRL, 32'h0000_0004);
        comp_chk(2'h1);
        vsync <= 1'b1;
        comp_chk(2'h3);
        vsync <= 1'b0;
        comp_chk(2'h3);
        vdischarge <= 1'b1;
        comp_chk(2'h3);
        vdischarge <= 1'b0;
        comp_chk(2'h1);
        vdischarge <= 1'b1;
        comp_chk(2'h3);
        vsync <= 1'b1;
        wait_n(2);
        vdischarge <= 1'b0;
        comp_chk(2'h1);
        vsync <= 1'b0;
        wr(`RGBL_OFS_CTRL, `RGBL_ZERO32);
        comp_chk(2'h3);
        $display("test composite done");

        wr(`RGBL_OFS_RAMP, `RGBL_ZERO32);
        wr(`RGBL_OFS_CTRL, 32'h0000_000C);
        wait_n(2);
        check({30'h0, line_drv, conv_drv}, 32'h2, "line first");
        tick();
        check({30'h0, line_drv, conv_drv}, 32'h3, "both on");
        $display("test drive start done");

        radiation <= 1'b1;
        wait_n(4);
        tick();
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_001C);
        tick();
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_000F);
        comp_chk(2'h1 | 2'h2);
        rd_chk(`RGBL_OFS_IRQ_STAT, 32'h0000_0001);
        check({31'h0, irq}, 32'h0, "masked interrupt");
        wr(`RGBL_OFS_IRQ_MASK, 32'h0000_0001);
        wait_n(2);
        check({31'h0, irq}, 32'h1, "unmasked interrupt");
        tick();
        check({30'h0, line_drv, conv_drv}, 32'h0, "drives off");
        radiation <= 1'b0;
        tick();
        tick();
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_0007);
        wr(`RGBL_OFS_CTRL, 32'h0000_000D);
        wait_n(2);
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_000C);
        rd_chk(`RGBL_OFS_CTRL, 32'h0000_000C);
        tick();
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_001C);
        wr(`RGBL_OFS_IRQ_STAT, 32'h0000_0001);
        wait_n(2);
        check({31'h0, irq}, 32'h0, "interrupt cleared");
        $display("test radiation trip done");

        radiation <= 1'b1;
        wait_n(4);
        tick();
        tick();
        radiation <= 1'b0;
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_000F);
        supply_ok <= 1'b0;
        comp_chk(2'h3);
        tick();
        supply_ok <= 1'b1;
        wait_n(5);
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_000C);
        tick();
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_001C);
        wr(`RGBL_OFS_CTRL, 32'h0000_0004);
        wait_n(1);
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_000C);
        tick();
        rd_chk(`RGBL_OFS_STATUS, 32'h0000_0004);
        $display("test supply drop and stop done");

        print_verdict();
    end
endmodule
`default_nettype wire

//--- verilog/rgbl_pkg.sv
// Types shared by the radiation guard and blanking logic.
// Assumes the offsets and counts of rgbl_regs.svh.
`default_nettype none
package rgbl_pkg;
    typedef struct packed {
        logic radiation;
        logic line;
        logic vsync;
        logic vdis;
        logic lock;
        logic supply_ok;
    } rgbl_pins_t;

    typedef enum logic [1:0] {
        RGBL_OFF     = 2'h0,
        RGBL_LINE_UP = 2'h1,
        RGBL_BOTH    = 2'h3,
        RGBL_LINE_DN = 2'h2
    } rgbl_ramp_t;
endpackage
`default_nettype wire

//--- verilog/rgbl_ramp.sv
// Soft phase-in and phase-out sequencer of line and converter drives.
// Assumes a one-cycle line tick and a synchronous run request.
`timescale 1ns/1ns
`default_nettype none
`include "rgbl_regs.svh"
module rgbl_ramp (
    input  wire logic                    clk_i,      // system clock
    input  wire logic                    rst_b_i,    // synced reset
    input  wire logic                    run_i,      // drives wanted
    input  wire logic                    tick_i,     // line tick
    input  wire logic [`RGBL_RAMP_W-1:0] steps_i,    // ramp lines
    output logic                         line_on_o,  // line drive
    output logic                         conv_on_o   // converter drive
);
    rgbl_pkg::rgbl_ramp_t    st_q, st_d;
    logic [`RGBL_RAMP_W-1:0] cnt_q, cnt_d;
    logic                    line_d, conv_d;
    logic                    done;

    always_comb
    begin
        done   = (cnt_q >= steps_i) && tick_i;
        st_d   = st_q;
        cnt_d  = tick_i ? cnt_q + 1'b1 : cnt_q;
        unique case (st_q)
            rgbl_pkg::RGBL_OFF:
                if (run_i)
                begin
                    st_d  = rgbl_pkg::RGBL_LINE_UP;
                    cnt_d = '0;
                end
            rgbl_pkg::RGBL_LINE_UP:
                if (!run_i)
                begin
                    st_d  = rgbl_pkg::RGBL_LINE_DN;
                    cnt_d = '0;
                end
                else if (done)
                    st_d = rgbl_pkg::RGBL_BOTH;
            rgbl_pkg::RGBL_BOTH:
                if (!run_i)
                begin
                    st_d  = rgbl_pkg::RGBL_LINE_DN;
                    cnt_d = '0;
                end
            rgbl_pkg::RGBL_LINE_DN:
                if (run_i)
                begin
                    st_d  = rgbl_pkg::RGBL_LINE_UP;
                    cnt_d = '0;
                end
                else if (done)
                    st_d = rgbl_pkg::RGBL_OFF;
        endcase
        line_d = (st_d != rgbl_pkg::RGBL_OFF);
        conv_d = (st_d == rgbl_pkg::RGBL_BOTH);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_q      <= rgbl_pkg::RGBL_OFF;
            cnt_q     <= '0;
            line_on_o <= 1'b0;
            conv_on_o <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            line_on_o <= line_d;
            conv_on_o <= conv_d;
        end
    end

    ramp_order_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        conv_on_o |-> line_on_o)
        else $error("converter drive on without line drive");
endmodule
`default_nettype wire

//--- verilog/rgbl_regs.svh
// Register offsets, field positions, reset values and counts of the
// radiation guard and blanking logic. Definitions only.
`ifndef RGBL_REGS_SVH
`define RGBL_REGS_SVH
`define RGBL_ADDR_W       5
`define RGBL_OFS_CTRL     5'h00
`define RGBL_OFS_STATUS   5'h04
`define RGBL_OFS_IRQ_STAT 5'h08
`define RGBL_OFS_IRQ_MASK 5'h0C
`define RGBL_OFS_RAMP     5'h10
`define RGBL_CTRL_CLR     0
`define RGBL_CTRL_HOLD    1
`define RGBL_CTRL_VEN     2
`define RGBL_CTRL_DRV     3
`define RGBL_CTRL_RST     3'h3
`define RGBL_ST_ALARM     0
`define RGBL_ST_PROT      1
`define RGBL_ST_LOCK      2
`define RGBL_ST_LINE      3
`define RGBL_ST_CONV      4
`define RGBL_IRQ_TRIP     0
`define RGBL_IRQ_UNLOCK   1
`define RGBL_IRQ_W        2
`define RGBL_IRQ_ZERO     2'h0
`define RGBL_XR_LINES     2'h2
`define RGBL_RAMP_W       8
`define RGBL_RAMP_RST     8'h10
`define RGBL_ZERO32       32'h0000_0000
`endif

//--- verilog/rgbl_top.sv
// Radiation guard, drive sequencing and lock/blank composite indication.
// Assumes asynchronous pins, a line pulse as timing base, Avalon-MM host.
`timescale 1ns/1ns
`default_nettype none
`include "rgbl_regs.svh"
module rgbl_top (
    input  wire logic                   ref_clk_i,        // 10 MHz clock
    input  wire logic                   rst_b_i,          // async reset
    input  wire logic [`RGBL_ADDR_W-1:0] avs_address_i,   // byte address
    input  wire logic                   avs_read_i,       // read request
    input  wire logic                   avs_write_i,      // write request
    input  wire logic [31:0]            avs_writedata_i,  // write data
    input  wire logic [3:0]             avs_byteenable_i, // byte lanes
    output logic [31:0]                 avs_readdata_o,   // read data
    output logic                        avs_waitrequest_o,// stall
    input  wire logic                   radiation_sense_i,// comparator
    input  wire logic                   line_pulse_i,     // line timing
    input  wire logic                   vsync_i,          // vertical sync
    input  wire logic                   vdischarge_i,     // osc discharge
    input  wire logic                   loop_lock_i,      // phase lock
    input  wire logic                   supply_ok_i,      // supply good
    output logic                        line_drive_out_o, // line drive
    output logic                        converter_drive_out_o, // conv
    output logic [1:0]                  lock_blank_composite_out_o, // lvl
    output logic                        irq_o             // interrupt
);
    logic                    rst_s1_q, rst_n;
    rgbl_pkg::rgbl_pins_t    pin_raw, pin_s1_q, pin_s2_q, pin_s3_q;
    logic                    line_tick, vs_rise, vd_rise, vd_fall;
    logic                    wait_q, wait_d;
    logic [31:0]             rdata_q, rdata_d;
    logic                    hold_q, hold_d, ven_q, ven_d, drv_q, drv_d;
    logic [`RGBL_RAMP_W-1:0] ramp_q, ramp_d;
    logic [`RGBL_IRQ_W-1:0]  stat_q, stat_d, mask_q, mask_d, ev;
    logic                    irq_d;
    logic [1:0]              rcnt_q, rcnt_d;
    logic                    prot_q, prot_d, alarm_q, alarm_d;
    logic                    trip, clear;
    logic                    eb_q, eb_d, force_blank;
    logic [1:0]              comp_d;
    logic                    wr_go, rd_go;

    function automatic logic hit(input logic [`RGBL_ADDR_W-1:0] a,
                                 input logic [`RGBL_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Reset is released through two flops so release is glitch free.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    assign pin_raw = '{radiation: radiation_sense_i, line: line_pulse_i,
                       vsync: vsync_i, vdis: vdischarge_i,
                       lock: loop_lock_i, supply_ok: supply_ok_i};

    // Third stage only serves edge detection; logic reads stage two on.
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign line_tick = pin_s2_q.line & ~pin_s3_q.line;
    assign vs_rise   = pin_s2_q.vsync & ~pin_s3_q.vsync;
    assign vd_rise   = pin_s2_q.vdis & ~pin_s3_q.vdis;
    assign vd_fall   = ~pin_s2_q.vdis & pin_s3_q.vdis;

    // Bus slave: one wait cycle, then a single cycle with waitrequest low.
    assign wr_go = avs_write_i & ~wait_q;
    assign rd_go = avs_read_i & ~wait_q;

    always_comb
    begin
        wait_d  = ~((avs_read_i | avs_write_i) & wait_q);
        rdata_d = rdata_q;
        if (avs_read_i & wait_q)
        begin
            rdata_d = `RGBL_ZERO32;
            if (hit(avs_address_i, `RGBL_OFS_CTRL))
            begin
                rdata_d[`RGBL_CTRL_HOLD] = hold_q;
                rdata_d[`RGBL_CTRL_VEN]  = ven_q;
                rdata_d[`RGBL_CTRL_DRV]  = drv_q;
            end
            if (hit(avs_address_i, `RGBL_OFS_STATUS))
            begin
                rdata_d[`RGBL_ST_ALARM] = alarm_q;
                rdata_d[`RGBL_ST_PROT]  = prot_q;
                rdata_d[`RGBL_ST_LOCK]  = pin_s2_q.lock;
                rdata_d[`RGBL_ST_LINE]  = line_drive_out_o;
                rdata_d[`RGBL_ST_CONV]  = converter_drive_out_o;
            end
            if (hit(avs_address_i, `RGBL_OFS_IRQ_STAT))
                rdata_d[`RGBL_IRQ_W-1:0] = stat_q;
            if (hit(avs_address_i, `RGBL_OFS_IRQ_MASK))
                rdata_d[`RGBL_IRQ_W-1:0] = mask_q;
            if (hit(avs_address_i, `RGBL_OFS_RAMP))
                rdata_d[`RGBL_RAMP_W-1:0] = ramp_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q  <= 1'b1;
            rdata_q <= `RGBL_ZERO32;
        end
        else
        begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata_q;

    // Control registers; only byte lane zero carries control bits.
    assign clear = wr_go & avs_byteenable_i[0] &
                   hit(avs_address_i, `RGBL_OFS_CTRL) &
                   avs_writedata_i[`RGBL_CTRL_CLR];

    always_comb
    begin
        hold_d = hold_q;
        ven_d  = ven_q;
        drv_d  = drv_q;
        ramp_d = ramp_q;
        mask_d = mask_q;
        if (wr_go & avs_byteenable_i[0])
        begin
            if (hit(avs_address_i, `RGBL_OFS_CTRL))
            begin
                hold_d = avs_writedata_i[`RGBL_CTRL_HOLD];
                ven_d  = avs_writedata_i[`RGBL_CTRL_VEN];
                drv_d  = avs_writedata_i[`RGBL_CTRL_DRV];
            end
            if (hit(avs_address_i, `RGBL_OFS_IRQ_MASK))
                mask_d = avs_writedata_i[`RGBL_IRQ_W-1:0];
            if (hit(avs_address_i, `RGBL_OFS_RAMP))
                ramp_d = avs_writedata_i[`RGBL_RAMP_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {drv_q, ven_q, hold_q} <= `RGBL_CTRL_RST;
            ramp_q <= `RGBL_RAMP_RST;
            mask_q <= `RGBL_IRQ_ZERO;
        end
        else
        begin
            hold_q <= hold_d;
            ven_q  <= ven_d;
            drv_q  <= drv_d;
            ramp_q <= ramp_d;
            mask_q <= mask_d;
        end
    end

    // Radiation filter: a spike that spans fewer than two line ticks is ignored.
    always_comb
    begin
        rcnt_d = rcnt_q;
        if (!pin_s2_q.radiation || prot_q)
            rcnt_d = '0;
        else if (line_tick)
            rcnt_d = rcnt_q + 1'b1;
        trip = pin_s2_q.radiation & ~prot_q & line_tick &
               (rcnt_q + 1'b1 == `RGBL_XR_LINES);
        prot_d  = prot_q;
        alarm_d = alarm_q;
        if (clear || !pin_s2_q.supply_ok)
        begin
            prot_d  = 1'b0;
            alarm_d = 1'b0;
        end
        if (trip)
        begin
            prot_d  = 1'b1;
            alarm_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rcnt_q  <= '0;
            prot_q  <= 1'b0;
            alarm_q <= 1'b0;
        end
        else
        begin
            rcnt_q  <= rcnt_d;
            prot_q  <= prot_d;
            alarm_q <= alarm_d;
        end
    end

    // Drives restart through the sequencer once the latch is cleared.
    rgbl_ramp u_ramp (
        .clk_i     (ref_clk_i),
        .rst_b_i   (rst_n),
        .run_i     (drv_q & pin_s2_q.supply_ok & ~prot_q),
        .tick_i    (line_tick),
        .steps_i   (ramp_q),
        .line_on_o (line_drive_out_o),
        .conv_on_o (converter_drive_out_o)
    );

    // Early blank and composite level.
    assign force_blank = ~pin_s2_q.supply_ok | prot_q | ~ven_q;

    always_comb
    begin
        eb_d = eb_q;
        if (vd_fall)
            eb_d = 1'b0;
        if (vs_rise | vd_rise)
            eb_d = 1'b1;
        comp_d[1] = force_blank | hold_q | eb_q;
        comp_d[0] = pin_s2_q.lock;
    end

    // Interrupt events: a set in the clearing cycle wins.
    assign ev[`RGBL_IRQ_TRIP]   = trip;
    assign ev[`RGBL_IRQ_UNLOCK] = ~pin_s2_q.lock & pin_s3_q.lock;

    always_comb
    begin
        stat_d = stat_q;
        if (wr_go & avs_byteenable_i[0] &
            hit(avs_address_i, `RGBL_OFS_IRQ_STAT))
            stat_d = stat_q & ~avs_writedata_i[`RGBL_IRQ_W-1:0];
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eb_q   <= 1'b0;
            lock_blank_composite_out_o <= 2'h0;
            stat_q <= `RGBL_IRQ_ZERO;
            irq_o  <= 1'b0;
        end
        else
        begin
            eb_q   <= eb_d;
            lock_blank_composite_out_o <= comp_d;
            stat_q <= stat_d;
            irq_o  <= irq_d;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    trip_two_lines_a: assert property (
        pin_s2_q.radiation && !prot_q && rcnt_q == 2'h1 && line_tick
        |=> prot_q)
        else $error("no trip after two line periods");
    no_early_trip_a: assert property (
        $rose(prot_q) |-> $past(rcnt_q) == 2'h1)
        else $error("trip before two line periods");
    drive_off_a: assert property (
        prot_q |=> !converter_drive_out_o)
        else $error("converter drive on while protected");
    alarm_set_a: assert property (
        $rose(prot_q) |-> alarm_q)
        else $error("alarm flag not set on trip");
    latch_hold_a: assert property (
        prot_q && !clear && pin_s2_q.supply_ok |=> prot_q)
        else $error("protection released without cause");
    clear_alarm_a: assert property (
        clear && !trip |=> !prot_q && !alarm_q)
        else $error("clear did not release latch and alarm");
    line_last_off_a: assert property (
        $fell(line_drive_out_o) |-> !converter_drive_out_o)
        else $error("line drive off before converter drive");
    comp_lock_a: assert property (
        lock_blank_composite_out_o[0] == $past(pin_s2_q.lock))
        else $error("composite lock level wrong");
    blank_start_a: assert property (
        vs_rise || vd_rise |=> eb_q)
        else $error("early blank did not start");
    blank_end_a: assert property (
        vd_fall && !vs_rise && !vd_rise |=> !eb_q)
        else $error("early blank did not end");
    blank_force_a: assert property (
        force_blank || hold_q |=> lock_blank_composite_out_o[1])
        else $error("permanent blanking missing");
    blank_pulse_a: assert property (
        !force_blank && !hold_q && !eb_q |=> !lock_blank_composite_out_o[1])
        else $error("blanking outside pulse");
    bus_answer_a: assert property (
        (avs_read_i || avs_write_i) && wait_q |=> !wait_q ##1 wait_q)
        else $error("bus answer not one cycle");

    trip_c: cover property ($rose(prot_q));
    restart_c: cover property ($fell(prot_q) ##[1:200]
        $rose(converter_drive_out_o));
    pulse_blank_c: cover property (!hold_q && $rose(eb_q));
    irq_c: cover property ($rose(irq_o));
endmodule
`default_nettype wire
